// file: hw/lie_pkg.sv
// Constants, opcodes and state types for the long-integer and load execution datapath
package lie_pkg;

  // ==========================================================================
  // Register file geometry
  localparam int unsigned LIE_ENTRIES    = 272;
  localparam logic [8:0]  LIE_LAST_IDX   = 9'h10F;
  localparam logic [8:0]  LIE_TMP32_BASE = 9'h100;
  localparam logic [8:0]  LIE_TMP64_BASE = 9'h108;
  localparam logic [8:0]  LIE_SCR32      = 9'h000;
  localparam logic [8:0]  LIE_SCR64      = 9'h080;
  localparam logic [8:0]  LIE_ARG32      = 9'h001;
  localparam logic [8:0]  LIE_ARG64      = 9'h081;
  localparam logic [3:0]  LIE_DEPTH      = 4'h8;
  localparam logic [3:0]  LIE_ARG_LAST   = 4'h8;
  localparam logic [8:0]  LIE_SEL_RST    = 9'h000;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OP_OPEN  = 8'h14;
  localparam logic [7:0] OP_INC   = 8'hBD;
  localparam logic [7:0] OP_MAX   = 8'hC5;
  localparam logic [7:0] OP_MIN   = 8'hC4;
  localparam logic [7:0] OP_MULR  = 8'h9F;
  localparam logic [7:0] OP_MULI  = 8'hB1;
  localparam logic [7:0] OP_MULS  = 8'hA8;
  localparam logic [7:0] OP_NEG   = 8'hBB;
  localparam logic [7:0] OP_NOT   = 8'hBF;
  localparam logic [7:0] OP_LOADR = 8'h0A;
  localparam logic [7:0] OP_COPYW = 8'h0B;
  localparam logic [7:0] OP_LOADB = 8'h59;
  localparam logic [7:0] OP_EULER = 8'h5D;
  localparam logic [7:0] OP_LIND  = 8'h7A;

  // ==========================================================================
  // Values and status layout
  localparam logic [31:0] LIE_NAN32      = 32'h8000_0000;
  localparam logic [63:0] LIE_NAN64      = 64'h8000_0000_0000_0000;
  localparam logic [31:0] LIE_E32        = 32'h402D_F854;
  localparam logic [63:0] LIE_E64        = 64'h4005_BF0A_8B14_5769;
  localparam logic [7:0]  LIE_F32_BIAS   = 8'h7F;
  localparam logic [10:0] LIE_F64_BIAS   = 11'h3FF;
  localparam int unsigned LIE_ST_ZERO    = 0;
  localparam int unsigned LIE_ST_SIGN    = 1;
  localparam logic [7:0]  LIE_STATUS_RST = 8'h00;

  typedef enum logic [1:0] {LIE_OPC, LIE_ARG, LIE_IND} lie_phase_e;

  typedef struct packed {
    lie_phase_e                        phase;
    logic [7:0]                        op;
    logic [LIE_ENTRIES-1:0][63:0]      regs;
    logic [8:0]                        work_sel;
    logic [7:0][8:0]                   stack;
    logic [3:0]                        level;
    logic [7:0]                        status;
    logic [3:0]                        arg_cnt;
    logic [63:0]                       ind_ptr;
    logic [63:0]                       peek;
  } lie_state_s;

endpackage

// file: hw/lie_int_alu.sv
// Long integer arithmetic unit: increment, max, min, multiply, negate, invert, pass
`timescale 1ns/1ps
module lie_int_alu
  import lie_pkg::*;
(
  // Operation
  input  wire logic [7:0]  i_op,
  input  wire logic        i_is64,
  input  wire logic [63:0] i_a,
  input  wire logic [63:0] i_b,
  // Result
  output logic      [63:0] o_res,
  output logic      [7:0]  o_flags
);

  // Operands arrive sign-extended to 64 bits, so one signed compare serves both widths
  always_comb begin
    logic [63:0] r;
    logic        nan_a;
    logic        nan_b;
    logic [63:0] nan_v;
    r     = i_a;
    nan_a = i_is64 ? (i_a == LIE_NAN64) : (i_a[31:0] == LIE_NAN32);
    nan_b = i_is64 ? (i_b == LIE_NAN64) : (i_b[31:0] == LIE_NAN32);
    nan_v = i_is64 ? LIE_NAN64 : {{32{1'b1}}, LIE_NAN32};
    case (i_op)
      OP_INC: r = i_a + 64'h0000_0000_0000_0001;
      OP_MAX: begin
        if (nan_a || nan_b) r = nan_v;
        else r = ($signed(i_a) > $signed(i_b)) ? i_a : i_b;
      end
      OP_MIN: begin
        if (nan_a || nan_b) r = nan_v;
        else r = ($signed(i_a) < $signed(i_b)) ? i_a : i_b;
      end
      OP_MULR, OP_MULI, OP_MULS: r = i_a * i_b;
      OP_NEG: r = 64'h0000_0000_0000_0000 - i_a;
      OP_NOT: r = ~i_a;
      default: r = i_a;
    endcase
    if (!i_is64) r = {{32{r[31]}}, r[31:0]};
    o_res = r;
    o_flags = LIE_STATUS_RST;
    o_flags[LIE_ST_ZERO] = (r == 64'h0000_0000_0000_0000);
    o_flags[LIE_ST_SIGN] = r[63];
  end

endmodule

// file: hw/lie_exec.sv
// Execution datapath for parenthesis, long integer and scratch-load opcodes
`timescale 1ns/1ps
module lie_exec
  import lie_pkg::*;
(
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_ce,
  // Instruction bytes
  input  wire logic        i_byte_valid,
  input  wire logic [7:0]  i_byte,
  output logic             o_byte_ready,
  // Selection control
  input  wire logic        i_close_paren,
  input  wire logic        i_sel_valid,
  input  wire logic [7:0]  i_sel_idx,
  input  wire logic        i_arg_mode,
  // Indirect lookup
  output logic             o_ind_req,
  output logic      [63:0] o_ind_ptr,
  input  wire logic        i_ind_ack,
  input  wire logic [63:0] i_ind_data,
  input  wire logic        i_ind_is64,
  // State view
  input  wire logic [8:0]  i_peek_idx,
  output logic      [63:0] o_peek_data,
  output logic      [7:0]  o_status,
  output logic      [8:0]  o_work_sel,
  output logic      [3:0]  o_level,
  output logic             o_busy
);

  // ==========================================================================
  // Helpers
  function automatic logic is64_idx(input logic [8:0] idx);
    return idx[8] ? idx[3] : idx[7];
  endfunction

  // Narrowing keeps the low word; widening sign-extends
  function automatic logic [63:0] fit(input logic [63:0] raw, input logic src64,
                                      input logic want64);
    logic [63:0] v;
    v = src64 ? raw : {{32{raw[31]}}, raw[31:0]};
    return want64 ? v : {{32{v[31]}}, v[31:0]};
  endfunction

  function automatic logic [63:0] store(input logic [63:0] v, input logic dst64);
    return dst64 ? v : {32'h0000_0000, v[31:0]};
  endfunction

  function automatic logic needs_arg(input logic [7:0] op);
    return (op == OP_INC) || (op == OP_MAX) || (op == OP_MIN) || (op == OP_MULR) ||
           (op == OP_MULI) || (op == OP_LOADR) || (op == OP_LOADB) || (op == OP_LIND);
  endfunction

  function automatic logic [63:0] byte_to_float(input logic [7:0] b, input logic f64);
    logic [7:0]  m;
    logic [7:0]  norm;
    logic [2:0]  p;
    logic [31:0] s32;
    logic [63:0] s64;
    m = b[7] ? (8'h00 - b) : b;
    p = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (m[i]) p = 3'(i);
    end
    norm = m << (3'h7 - p);
    s32 = {b[7], LIE_F32_BIAS + {5'h00, p}, norm[6:0], 16'h0000};
    s64 = {b[7], LIE_F64_BIAS + {8'h00, p}, norm[6:0], 45'h0};
    if (m == 8'h00) return 64'h0000_0000_0000_0000;
    return f64 ? s64 : {32'h0000_0000, s32};
  endfunction

  // ==========================================================================
  // State
  lie_state_s  q;
  lie_state_s  d;

  logic        acc;
  logic        ex_valid;
  logic [7:0]  ex_op;
  logic [7:0]  ex_arg;
  logic        a64;
  logic [63:0] wv;
  logic [63:0] rv;
  logic [63:0] own_val;
  logic [8:0]  tmp_sel;
  logic [8:0]  scr_dst;
  logic [2:0]  pop_idx;
  logic        alu_is64;
  logic [63:0] alu_a;
  logic [63:0] alu_b;
  logic [63:0] alu_res;
  logic [7:0]  alu_flags;

  // Close and select take the cycle ahead of an instruction byte, which then stalls
  assign o_byte_ready = (q.phase != LIE_IND) && !i_close_paren && !i_sel_valid;
  assign acc          = i_ce && i_byte_valid && o_byte_ready;
  assign o_ind_req    = (q.phase == LIE_IND);
  assign o_ind_ptr    = q.ind_ptr;
  assign o_peek_data  = q.peek;
  assign o_status     = q.status;
  assign o_work_sel   = q.work_sel;
  assign o_level      = q.level;
  assign o_busy       = (q.phase != LIE_OPC);

  assign a64     = is64_idx(q.work_sel);
  assign wv      = fit(q.regs[q.work_sel], a64, a64);
  assign rv      = fit(q.regs[{1'b0, ex_arg}], is64_idx({1'b0, ex_arg}), a64);
  assign own_val = fit(q.regs[{1'b0, ex_arg}], is64_idx({1'b0, ex_arg}),
                       is64_idx({1'b0, ex_arg}));
  assign tmp_sel = (a64 ? LIE_TMP64_BASE : LIE_TMP32_BASE) + {5'h00, q.level};
  assign pop_idx = 3'(q.level - 4'h1);
  assign scr_dst = i_arg_mode ? ((a64 ? LIE_ARG64 : LIE_ARG32) + {5'h00, q.arg_cnt})
                              : (a64 ? LIE_SCR64 : LIE_SCR32);

  // An instruction other than OP_LIND executes once its last byte is taken; OP_LIND loads on the lookup answer
  always_comb begin
    ex_valid = 1'b0;
    ex_op    = q.op;
    ex_arg   = i_byte;
    if (acc && (q.phase == LIE_OPC) && !needs_arg(i_byte)) begin
      ex_valid = 1'b1;
      ex_op    = i_byte;
    end else if (acc && (q.phase == LIE_ARG) && (q.op != OP_LIND)) begin
      ex_valid = 1'b1;
    end
  end

  assign alu_is64 = (ex_op == OP_INC) ? is64_idx({1'b0, ex_arg}) : a64;

  always_comb begin
    alu_a = wv;
    alu_b = rv;
    case (ex_op)
      OP_INC:   alu_a = own_val;
      OP_LOADR: alu_a = rv;
      OP_MULI:  alu_b = {{56{ex_arg[7]}}, ex_arg};
      OP_MULS:  alu_b = fit(q.regs[a64 ? LIE_SCR64 : LIE_SCR32], a64, a64);
      default:  alu_b = rv;
    endcase
  end

  lie_int_alu lie_int_alu_i (
    .i_op    (ex_op),
    .i_is64  (alu_is64),
    .i_a     (alu_a),
    .i_b     (alu_b),
    .o_res   (alu_res),
    .o_flags (alu_flags)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    logic        load_en;
    logic [63:0] load_v;
    d       = q;
    load_en = 1'b0;
    load_v  = 64'h0000_0000_0000_0000;
    d.peek  = (i_peek_idx <= LIE_LAST_IDX) ? q.regs[i_peek_idx] : 64'h0000_0000_0000_0000;
    if (!i_arg_mode) d.arg_cnt = 4'h0;
    if (i_close_paren) begin
      if (q.level != 4'h0) begin
        d.level    = q.level - 4'h1;
        d.work_sel = q.stack[pop_idx];
      end
    end else if (i_sel_valid) begin
      d.work_sel = {1'b0, i_sel_idx};
    end
    case (q.phase)
      LIE_OPC: begin
        if (acc) begin
          d.op = i_byte;
          if (needs_arg(i_byte)) d.phase = LIE_ARG;
        end
      end
      LIE_ARG: begin
        if (acc) begin
          if (q.op == OP_LIND) begin
            d.ind_ptr = q.regs[{1'b0, i_byte}];
            d.phase   = LIE_IND;
          end else begin
            d.phase = LIE_OPC;
          end
        end
      end
      LIE_IND: begin
        if (i_ind_ack) begin
          load_en = 1'b1;
          load_v  = fit(i_ind_data, i_ind_is64, a64);
          d.phase = LIE_OPC;
        end
      end
      default: d.phase = LIE_OPC;
    endcase
    if (ex_valid) begin
      case (ex_op)
        OP_OPEN: begin
          if (q.level == LIE_DEPTH) begin
            d.regs[q.work_sel] = store(a64 ? LIE_NAN64 : {32'h0000_0000, LIE_NAN32}, a64);
            d.level = 4'h0;
          end else begin
            d.stack[q.level[2:0]] = q.work_sel;
            d.regs[tmp_sel]       = store(wv, a64);
            d.work_sel            = tmp_sel;
            d.level               = q.level + 4'h1;
          end
        end
        OP_INC: begin
          d.regs[{1'b0, ex_arg}] = store(alu_res, alu_is64);
          d.status               = alu_flags;
        end
        OP_MAX, OP_MIN, OP_MULR, OP_MULI, OP_MULS, OP_NEG, OP_NOT: begin
          d.regs[q.work_sel] = store(alu_res, a64);
          d.status           = alu_flags;
        end
        OP_LOADR, OP_COPYW: begin
          load_en  = 1'b1;
          load_v   = alu_res;
          d.status = alu_flags;
        end
        OP_LOADB: begin
          load_en = 1'b1;
          load_v  = byte_to_float(ex_arg, a64);
        end
        OP_EULER: begin
          load_en = 1'b1;
          load_v  = a64 ? LIE_E64 : {32'h0000_0000, LIE_E32};
        end
        default: load_en = 1'b0;
      endcase
    end
    if (load_en) begin
      d.regs[scr_dst] = store(load_v, a64);
      if (i_arg_mode && (q.arg_cnt != LIE_ARG_LAST)) d.arg_cnt = q.arg_cnt + 4'h1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q.phase    <= LIE_OPC;
      q.op       <= 8'h00;
      q.regs     <= '0;
      q.work_sel <= LIE_SEL_RST;
      q.stack    <= '0;
      q.level    <= 4'h0;
      q.status   <= LIE_STATUS_RST;
      q.arg_cnt  <= 4'h0;
      q.ind_ptr  <= 64'h0000_0000_0000_0000;
      q.peek     <= 64'h0000_0000_0000_0000;
    end else if (i_ce) begin
      q <= d;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_take_argop;
    acc && (q.phase == LIE_OPC) && needs_arg(i_byte);
  endsequence

  sequence s_open_room;
    ex_valid && (ex_op == OP_OPEN) && (q.level < LIE_DEPTH);
  endsequence

  a_arg_wait: assert property (s_take_argop |=> (q.phase == LIE_ARG) &&
                               (q.op == $past(i_byte)))
    else $error("operand opcode did not wait for its byte");

  a_open_push: assert property (s_open_room |=> (q.level == $past(q.level) + 4'h1) &&
                                (q.work_sel == $past(tmp_sel)) &&
                                (q.stack[$past(q.level[2:0])] == $past(q.work_sel)))
    else $error("open parenthesis did not push and select temporary");

  a_open_copy: assert property (s_open_room |=> q.regs[q.work_sel][31:0] ==
                                $past(wv[31:0]))
    else $error("temporary does not hold the working value");

  a_open_overflow: assert property (ex_valid && (ex_op == OP_OPEN) &&
                                    (q.level == LIE_DEPTH) |=> (q.level == 4'h0) &&
                                    (q.regs[q.work_sel] ==
                                     ($past(a64) ? LIE_NAN64 : 64'(LIE_NAN32))))
    else $error("overflow did not give NaN and level zero");

  a_close_restore: assert property (i_ce && i_close_paren && (q.level != 4'h0) |=>
                                    (q.work_sel == $past(q.stack[pop_idx])) &&
                                    (q.level == $past(q.level) - 4'h1))
    else $error("close parenthesis did not restore selection");

  a_inc_adds: assert property (ex_valid && (ex_op == OP_INC) |=>
                               q.regs[$past({1'b0, ex_arg})][31:0] ==
                               $past(own_val[31:0]) + 32'h0000_0001)
    else $error("increment result wrong");

  a_status_set: assert property (ex_valid && ((ex_op == OP_NEG) || (ex_op == OP_MULR)) |=>
                                 q.status[LIE_ST_ZERO] == (q.regs[q.work_sel] == 64'h0))
    else $error("status zero flag does not match result");

  a_negate_result: assert property (ex_valid && (ex_op == OP_NEG) |=>
                             q.regs[q.work_sel][31:0] == 32'h0000_0000 - $past(wv[31:0]))
    else $error("negate result wrong");

  a_invert_result: assert property (ex_valid && (ex_op == OP_NOT) |=>
                             q.regs[q.work_sel][31:0] == ~$past(wv[31:0]))
    else $error("invert result wrong");

  a_euler_load: assert property (ex_valid && (ex_op == OP_EULER) && !i_arg_mode && !a64 |=>
                                 q.regs[LIE_SCR32][31:0] == LIE_E32)
    else $error("euler constant not in scratch");

  a_ind_hold: assert property (i_ce && o_ind_req && !i_ind_ack |=> o_ind_req &&
                               $stable(o_ind_ptr))
    else $error("indirect request dropped before answer");

endmodule

// file: dv/lie_ibuf_model.sv
// Instruction-byte source and pointer-lookup responder facing the datapath
`timescale 1ns/1ps
module lie_ibuf_model (
  // Clock and enable
  input  wire logic        i_core_clk,
  input  wire logic        i_ce,
  // Instruction bytes
  input  wire logic        i_byte_ready,
  output logic             o_byte_valid,
  output logic      [7:0]  o_byte,
  // Pointer lookup
  input  wire logic        i_ind_req,
  output logic             o_ind_ack,
  output logic      [63:0] o_ind_data,
  output logic             o_ind_is64
);
  // ==========================================================================
  // Pending bytes and lookup answer, filled by the bench
  logic [7:0]  fifo_q[$];
  logic [63:0] ans_data;
  logic        ans_is64;
  int          ans_wait;
  int          wait_cnt;

  initial begin
    o_byte_valid = 1'b0;
    o_byte = 8'h00;
    o_ind_ack = 1'b0;
    o_ind_data = 64'h0;
    o_ind_is64 = 1'b0;
    ans_data = 64'h0;
    ans_is64 = 1'b0;
    ans_wait = 0;
    wait_cnt = 0;
  end

  // ==========================================================================
  // Byte source
  // A refused byte is held; an empty line toggles so stale data never looks valid
  always @(posedge i_core_clk) begin
    if (o_byte_valid && i_byte_ready && i_ce) begin
      void'(fifo_q.pop_front());
    end
    if (!o_byte_valid || (i_byte_ready && i_ce)) begin
      if (fifo_q.size() > 0 && $urandom_range(3) != 0) begin
        o_byte_valid <= 1'b1;
        o_byte <= fifo_q[0];
      end else begin
        o_byte_valid <= 1'b0;
        o_byte <= ~o_byte;
      end
    end
  end

  // ==========================================================================
  // Lookup responder
  // Answer pulse is held over disabled edges so it is never lost
  always @(posedge i_core_clk) begin
    wait_cnt <= (i_ind_req && !o_ind_ack) ? wait_cnt + 1 : 0;
    if (!(o_ind_ack && !i_ce)) begin
      if (i_ind_req && !o_ind_ack && wait_cnt >= ans_wait) begin
        o_ind_ack <= 1'b1;
        o_ind_data <= ans_data;
        o_ind_is64 <= ans_is64;
      end else begin
        o_ind_ack <= 1'b0;
        o_ind_data <= ~o_ind_data;
        o_ind_is64 <= ~o_ind_is64;
      end
    end
  end
endmodule

// file: dv/lie_exec_test.sv
// Self-checking bench for the long-integer and scratch-load execution datapath
`timescale 1ns/1ps
module lie_exec_test;
  import lie_pkg::*;

  // ==========================================================================
  // Design signals
  logic        i_core_clk, i_rst_b, i_ce, i_byte_valid, o_byte_ready, i_close_paren;
  logic        i_sel_valid, i_arg_mode, o_ind_req, i_ind_ack, i_ind_is64, o_busy;
  logic [7:0]  i_byte, i_sel_idx, o_status;
  logic [8:0]  i_peek_idx, o_work_sel;
  logic [3:0]  o_level;
  logic [63:0] o_ind_ptr, i_ind_data, o_peek_data;

  // ==========================================================================
  // Bench state
  typedef struct {
    int          kind;
    logic [63:0] val;
  } lie_note_s;
  lie_note_s   notes[$];
  lie_note_s   note;
  logic [63:0] got;
  logic        ce_rnd, peek_go, look_q, req_q;
  int          bad_count, cmp_count;
  string       kname[5] = '{"peek_data", "status", "work_sel", "level", "ind_ptr"};
  logic [7:0]  b;
  logic [31:0] p;
  logic [63:0] d;

  lie_exec lie_exec_i (
    .i_core_clk, .i_rst_b, .i_ce, .i_byte_valid, .i_byte, .o_byte_ready, .i_close_paren,
    .i_sel_valid, .i_sel_idx, .i_arg_mode, .o_ind_req, .o_ind_ptr, .i_ind_ack, .i_ind_data,
    .i_ind_is64, .i_peek_idx, .o_peek_data, .o_status, .o_work_sel, .o_level, .o_busy
  );

  lie_ibuf_model lie_ibuf_model_i (
    .i_core_clk, .i_ce, .i_byte_ready(o_byte_ready), .o_byte_valid(i_byte_valid),
    .o_byte(i_byte), .i_ind_req(o_ind_req), .o_ind_ack(i_ind_ack),
    .o_ind_data(i_ind_data), .o_ind_is64(i_ind_is64)
  );

  initial i_core_clk = 1'b0;
  always #2.5 i_core_clk = ~i_core_clk;
  // Enable stutters only during byte traffic, so peeks and pulses stay exact
  always @(posedge i_core_clk) i_ce <= ce_rnd ? ($urandom_range(3) != 0) : 1'b1;
  always @(posedge i_core_clk) look_q <= peek_go;
  always @(posedge i_core_clk) req_q <= o_ind_req;

  // ==========================================================================
  // Watcher: a peek answer or a fresh lookup request retires the oldest note
  always @(negedge i_core_clk) begin
    if (look_q || (o_ind_req === 1'b1 && req_q === 1'b0)) begin
      if (notes.size() == 0) begin
        bad_count++;
        $display("mismatch note_queue expected entry seen none");
      end else begin
        note = notes.pop_front();
        case (note.kind)
          0: got = o_peek_data;
          1: got = 64'(o_status);
          2: got = 64'(o_work_sel);
          3: got = 64'(o_level);
          default: got = o_ind_ptr;
        endcase
        cmp_count++;
        if (got !== note.val) begin
          bad_count++;
          $display("mismatch %s expected %h seen %h", kname[note.kind], note.val, got);
        end
      end
    end
  end

  // ==========================================================================
  // Tasks
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic send(input logic [7:0] v);
    ce_rnd = 1'b1;
    lie_ibuf_model_i.fifo_q.push_back(v);
  endtask

  task automatic op2(input logic [7:0] o, input logic [7:0] a);
    send(o);
    send(a);
  endtask

  task automatic idle();
    int n;
    ce_rnd = 1'b0;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while ((lie_ibuf_model_i.fifo_q.size() != 0 || i_byte_valid || o_busy || !i_ce)
               && n < 400);
    if (n >= 400) begin
      bad_count++;
      $display("mismatch idle expected 1 seen 0");
      print_verdict();
    end
  endtask

  task automatic ctl(input logic cls, input logic [7:0] idx);
    idle();
    i_close_paren <= cls;
    i_sel_valid <= !cls;
    i_sel_idx <= idx;
    @(posedge i_core_clk);
    i_close_paren <= 1'b0;
    i_sel_valid <= 1'b0;
  endtask

  task automatic look(input int kind, input logic [8:0] idx, input logic [63:0] val);
    idle();
    notes.push_back(lie_note_s'{kind, val});
    i_peek_idx <= idx;
    peek_go <= 1'b1;
    @(posedge i_core_clk);
    peek_go <= 1'b0;
    repeat (2) @(posedge i_core_clk);
  endtask

  task automatic ind(input logic [63:0] v, input logic w64, input int dly,
                     input logic [63:0] ptr);
    lie_ibuf_model_i.ans_data = v;
    lie_ibuf_model_i.ans_is64 = w64;
    lie_ibuf_model_i.ans_wait = dly;
    notes.push_back(lie_note_s'{4, ptr});
  endtask

  function automatic logic [31:0] f32(input logic [7:0] v);
    logic [63:0] r;
    logic [10:0] e;
    r = $realtobits(real'($signed(v)));
    e = r[62:52] - 11'h380;
    return (v == 8'h00) ? 32'h0000_0000 : {r[63], e[7:0], r[51:29]};
  endfunction

  // ==========================================================================
  // Main sequence
  initial begin
    i_rst_b = 1'b0;
    i_close_paren = 1'b0;
    i_sel_valid = 1'b0;
    i_sel_idx = 8'h00;
    i_arg_mode = 1'b0;
    i_peek_idx = 9'h000;
    {ce_rnd, peek_go} = 2'h0;
    bad_count = 0;
    cmp_count = 0;
    void'($urandom(83));
    repeat (16) @(posedge i_core_clk);
    i_rst_b <= 1'b1;

    op2(OP_INC, 8'h0A);
    op2(OP_INC, 8'h0A);
    op2(OP_INC, 8'hC8);
    look(0, 9'h00A, 64'h2);
    look(0, 9'h0C8, 64'h1);
    look(1, 9'h000, 64'h0);
    ctl(1'b0, 8'h0B);
    send(OP_NOT);
    look(0, 9'h00B, 64'hFFFF_FFFF);
    look(1, 9'h000, 64'h2);
    op2(OP_INC, 8'h0B);
    look(0, 9'h00B, 64'h0);
    look(1, 9'h000, 64'h1);
    $display("test done: increment and invert");

    b = 8'h80 | 8'($urandom_range(127));
    p = {{23{b[7]}}, b, 1'b0};
    ctl(1'b0, 8'h05);
    send(OP_NOT);
    send(OP_NEG);
    look(0, 9'h005, 64'h1);
    op2(OP_MULI, b);
    look(0, 9'h005, {32'h0, {24{b[7]}}, b});
    op2(OP_MULR, 8'h0A);
    look(0, 9'h005, {32'h0, p});
    send(OP_COPYW);
    look(0, LIE_SCR32, {32'h0, p});
    look(1, 9'h000, 64'h2);
    send(OP_MULS);
    look(0, 9'h005, {32'h0, p * p});
    $display("test done: multiply and negate");

    ctl(1'b0, 8'h06);
    send(OP_NOT);
    op2(OP_MAX, 8'h0A);
    look(0, 9'h006, 64'h2);
    op2(OP_MIN, 8'hC8);
    look(0, 9'h006, 64'h1);
    ctl(1'b0, 8'hC9);
    send(OP_NOT);
    op2(OP_MAX, 8'h00);
    look(0, 9'h0C9, 64'hFFFF_FFFF_FFFF_FFFF);
    op2(OP_MIN, 8'h00);
    look(0, 9'h0C9, {32'hFFFF_FFFF, p});
    look(1, 9'h000, 64'h2);
    $display("test done: maximum and minimum");

    ctl(1'b0, 8'h0A);
    send(OP_OPEN);
    look(2, 9'h000, 64'(LIE_TMP32_BASE));
    look(0, LIE_TMP32_BASE, 64'h2);
    repeat (7) send(OP_OPEN);
    look(3, 9'h000, 64'h8);
    look(0, LIE_TMP32_BASE + 9'h007, 64'h2);
    ctl(1'b1, 8'h00);
    look(3, 9'h000, 64'h7);
    look(2, 9'h000, 64'(LIE_TMP32_BASE + 9'h006));
    send(OP_OPEN);
    send(OP_OPEN);
    look(3, 9'h000, 64'h0);
    look(0, LIE_TMP32_BASE + 9'h007, 64'(LIE_NAN32));
    op2(OP_MAX, 8'h0A);
    look(0, LIE_TMP32_BASE + 9'h007, 64'(LIE_NAN32));
    ctl(1'b0, 8'hC8);
    send(OP_OPEN);
    look(2, 9'h000, 64'(LIE_TMP64_BASE));
    look(0, LIE_TMP64_BASE, 64'h1);
    ctl(1'b1, 8'h00);
    look(2, 9'h000, 64'h00C8);
    $display("test done: parentheses");

    ctl(1'b0, 8'h0A);
    i_arg_mode <= 1'b1;
    b = 8'($urandom_range(255));
    op2(OP_LOADR, 8'hC8);
    op2(OP_LOADB, b);
    send(OP_EULER);
    look(0, LIE_ARG32, 64'h1);
    look(0, LIE_ARG32 + 9'h001, {32'h0, f32(b)});
    look(0, LIE_ARG32 + 9'h002, {32'h0, LIE_E32});
    i_arg_mode <= 1'b0;
    send(OP_EULER);
    look(0, LIE_SCR32, {32'h0, LIE_E32});
    op2(OP_LOADR, 8'hC9);
    look(0, LIE_SCR32, {32'h0, p});
    ctl(1'b0, 8'hC8);
    send(OP_EULER);
    look(0, LIE_SCR64, LIE_E64);
    op2(OP_LOADB, b);
    look(0, LIE_SCR64, $realtobits(real'($signed(b))));
    op2(OP_LOADR, 8'h06);
    look(0, LIE_SCR64, 64'h1);
    ctl(1'b0, 8'hC9);
    send(OP_COPYW);
    look(0, LIE_SCR64, {32'hFFFF_FFFF, p});
    look(1, 9'h000, 64'h2);
    $display("test done: scratch loads");

    d = {$urandom, $urandom};
    ctl(1'b0, 8'h0A);
    ind(d, 1'b1, 0, 64'h2);
    op2(OP_LIND, 8'h0A);
    look(0, LIE_SCR32, {32'h0, d[31:0]});
    ctl(1'b0, 8'hC8);
    ind({32'h0, 1'b1, d[30:0]}, 1'b0, 5, 64'h1);
    op2(OP_LIND, 8'hC8);
    look(0, LIE_SCR64, {33'h1_FFFF_FFFF, d[30:0]});
    $display("test done: indirect fetch");
    print_verdict();
  end
endmodule
